// ### rtl/pd_trip.sv
`timescale 1ns/1ps
module pd_trip #(
  parameter int TICK_CYCLES = pd_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic advanced_io,
  input wire logic [4:0] term_closed,
  input wire logic [4:0] input_one_function_select,
  input wire logic [4:0] input_two_function_select,
  input wire logic [4:0] input_three_function_select,
  input wire logic [4:0] input_four_function_select,
  input wire logic [4:0] input_five_function_select,
  input wire logic trip_clear,
  input wire logic overload_trip,
  input wire logic ref_is_analog,
  input wire logic ref_is_comm,
  input wire logic ref_combined,
  input wire logic comm_lost,
  input wire logic [11:0] voltage_level,
  input wire logic [11:0] current_level,
  input wire logic [11:0] analog_input_min_level,
  input wire logic [11:0] voltage_input_min_level,
  input wire logic [11:0] current_input_min_level,
  input wire logic [1:0] loss_detect_mode,
  input wire logic [1:0] loss_reaction_select,
  input wire logic [10:0] loss_confirm_time,
  input wire logic [4:0] relay_function_select,
  input wire logic [4:0] output_two_function_select,
  input wire logic brake_limit_enable,
  input wire logic [4:0] brake_enable_duty,
  input wire logic brake_request,
  output logic output_block_r,
  output logic decel_stop_r,
  output logic ext_trip_a_r,
  output logic ext_trip_b_r,
  output logic overload_latch_r,
  output logic speed_loss_r,
  output logic fault_relay_contact_r,
  output logic output_two_r,
  output logic brake_drive_r
);
  logic rst_meta_r;
  logic rst_n_r;
  logic tick;
  logic [4:0] closed;
  logic [4:0] fsel [pd_pkg::TERMS];
  logic [4:0] no_hit;
  logic [4:0] nc_hit;
  logic [4:0] no_assigned;
  logic [4:0] nc_mask_r;
  logic [4:0] nc_mask_nxt;
  logic loss_cond;
  logic [11:0] v_thr;
  logic [11:0] i_thr;
  logic [11:0] a_thr;
  logic [10:0] confirm_r;
  logic [10:0] confirm_lim;
  logic [4:0] duty_lim;
  logic loss_block_r;
  logic [7:0] cont_r;
  logic [6:0] win_r;
  logic [6:0] on_r;
  logic brake_ok;
  pd_pkg::pd_brake_t brake_st_r;

  // reset: async assert, released through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // contacts come from the terminal block, outside the clock domain
  pd_sync #(.WIDTH(pd_pkg::TERMS)) u_sync (
    .clock(clock),
    .rst_n(rst_n_r),
    .async_in(term_closed),
    .sync_out(closed)
  );

  // 100 ms time base for confirm and braking counters
  pd_tick #(.PERIOD(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst_n(rst_n_r),
    .tick(tick)
  );

  assign fsel[0] = input_one_function_select;
  assign fsel[1] = input_two_function_select;
  assign fsel[2] = input_three_function_select;
  assign fsel[3] = input_four_function_select;
  assign fsel[4] = input_five_function_select;

  // per terminal trip decode; out-of-range codes act as no function
  genvar g;
  generate
    for (g = 0; g < pd_pkg::TERMS; g++) begin : g_term
      logic present;
      logic valid;
      assign present = (g < pd_pkg::STD_TERMS) || advanced_io;
      assign valid = present && (fsel[g] <= pd_pkg::FN_MAX);
      assign no_assigned[g] = valid && (fsel[g] == pd_pkg::FN_EXT_TRIP_NO);
      assign no_hit[g] = no_assigned[g] && closed[g];
      assign nc_hit[g] = valid && (fsel[g] == pd_pkg::FN_EXT_TRIP_NC) && !closed[g];
    end
  endgenerate

  // N.O. trip latch; a new short wins over a clear
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_trip_a_r <= 1'b0;
    end else if (|no_hit) begin
      ext_trip_a_r <= 1'b1;
    end else if (trip_clear) begin
      ext_trip_a_r <= 1'b0;
    end
  end

  // remember which terminals opened, so reassignment cannot clear it
  always_comb begin
    nc_mask_nxt = nc_mask_r & ~closed;
    nc_mask_nxt = nc_mask_nxt | nc_hit;
  end

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      nc_mask_r <= 5'h00;
    end else begin
      nc_mask_r <= nc_mask_nxt;
    end
  end

  // N.C. trip latch: clear needs every tripped contact closed again
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ext_trip_b_r <= 1'b0;
    end else if (|nc_hit) begin
      ext_trip_b_r <= 1'b1;
    end else if (trip_clear && (nc_mask_r == 5'h00)) begin
      ext_trip_b_r <= 1'b0;
    end
  end

  // drive overload trip held until cleared
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      overload_latch_r <= 1'b0;
    end else if (overload_trip) begin
      overload_latch_r <= 1'b1;
    end else if (trip_clear) begin
      overload_latch_r <= 1'b0;
    end
  end

  // thresholds: half or full minimum
  assign a_thr = (loss_detect_mode == pd_pkg::MODE_HALF) ? (analog_input_min_level >> 1) : analog_input_min_level;
  assign v_thr = (loss_detect_mode == pd_pkg::MODE_HALF) ? (voltage_input_min_level >> 1) : voltage_input_min_level;
  assign i_thr = (loss_detect_mode == pd_pkg::MODE_HALF) ? (current_input_min_level >> 1) : current_input_min_level;

  // loss only checked for analog or comm references
  always_comb begin
    loss_cond = 1'b0;
    if (loss_detect_mode == pd_pkg::MODE_HALF || loss_detect_mode == pd_pkg::MODE_FULL) begin
      if (ref_is_analog && ref_combined) begin
        loss_cond = (voltage_level < v_thr) || (current_level < i_thr);
      end else if (ref_is_analog) begin
        loss_cond = voltage_level < a_thr;
      end else if (ref_is_comm) begin
        loss_cond = comm_lost;
      end
    end
  end

  // out-of-range confirm time is clamped into 0.1..120.0 s
  assign confirm_lim = (loss_confirm_time < pd_pkg::CONFIRM_MIN) ? pd_pkg::CONFIRM_MIN :
                       (loss_confirm_time > pd_pkg::CONFIRM_MAX) ? pd_pkg::CONFIRM_MAX : loss_confirm_time;

  // confirm counter restarts whenever the condition drops
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      confirm_r <= 11'h000;
    end else if (!loss_cond) begin
      confirm_r <= 11'h000;
    end else if (tick && confirm_r < confirm_lim) begin
      confirm_r <= confirm_r + 11'h001;
    end
  end

  // loss status follows the confirmed condition
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      speed_loss_r <= 1'b0;
    end else begin
      speed_loss_r <= loss_cond && (confirm_r >= confirm_lim);
    end
  end

  // reaction latches; run-on reaction leaves the drive alone
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      loss_block_r <= 1'b0;
      decel_stop_r <= 1'b0;
    end else if (speed_loss_r) begin
      loss_block_r <= loss_block_r | (loss_reaction_select == pd_pkg::REACT_FREE);
      decel_stop_r <= decel_stop_r | (loss_reaction_select == pd_pkg::REACT_DECEL);
    end else if (trip_clear) begin
      loss_block_r <= 1'b0;
      decel_stop_r <= 1'b0;
    end
  end

  // any latched trip blocks the output stage
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      output_block_r <= 1'b0;
    end else begin
      output_block_r <= ext_trip_a_r | ext_trip_b_r | overload_latch_r | loss_block_r;
    end
  end

  // relay and output two selectors
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fault_relay_contact_r <= 1'b0;
      output_two_r <= 1'b0;
    end else begin
      fault_relay_contact_r <= (relay_function_select == pd_pkg::OUT_OVERLOAD && overload_latch_r) ||
                               (relay_function_select == pd_pkg::OUT_SPEED_LOSS && speed_loss_r);
      output_two_r <= (output_two_function_select == pd_pkg::OUT_OVERLOAD && overload_latch_r) ||
                      (output_two_function_select == pd_pkg::OUT_SPEED_LOSS && speed_loss_r);
    end
  end

  // duty above 30 % is clamped to 30
  assign duty_lim = (brake_enable_duty > pd_pkg::DUTY_MAX) ? pd_pkg::DUTY_MAX : brake_enable_duty;

  // duty window of 100 ticks: one tick is one percent of the cycle
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      win_r <= 7'h00;
      on_r <= 7'h00;
    end else if (tick) begin
      if (win_r == pd_pkg::DUTY_WINDOW_TICKS - 7'h01) begin
        win_r <= 7'h00;
        on_r <= 7'h00;
      end else begin
        win_r <= win_r + 7'h01;
        on_r <= on_r + {6'h00, brake_drive_r};
      end
    end
  end

  // limit only when enabled; coarse at tick grain by design
  assign brake_ok = !brake_limit_enable || (on_r < {2'h0, duty_lim});

  // continuous braking timer and cut-off state
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      brake_st_r <= pd_pkg::PD_BR_IDLE;
      cont_r <= 8'h00;
    end else begin
      case (brake_st_r)
        pd_pkg::PD_BR_IDLE: begin
          cont_r <= 8'h00;
          if (brake_request && brake_ok) begin
            brake_st_r <= pd_pkg::PD_BR_ON;
          end
        end
        pd_pkg::PD_BR_ON: begin
          if (!brake_request || !brake_ok) begin
            brake_st_r <= pd_pkg::PD_BR_IDLE;
          end else if (cont_r >= pd_pkg::BRAKE_CONT_TICKS) begin
            brake_st_r <= pd_pkg::PD_BR_HOLD;
          end else if (tick) begin
            cont_r <= cont_r + 8'h01;
          end
        end
        pd_pkg::PD_BR_HOLD: begin
          // stays off until the request is withdrawn
          if (!brake_request) begin
            brake_st_r <= pd_pkg::PD_BR_IDLE;
          end
        end
        default: begin
          brake_st_r <= pd_pkg::PD_BR_IDLE;
        end
      endcase
    end
  end

  // resistor drive only in the on state
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      brake_drive_r <= 1'b0;
    end else begin
      brake_drive_r <= (brake_st_r == pd_pkg::PD_BR_ON) && brake_request && brake_ok;
    end
  end

  // checks
  AST_NO_TRIP: assert property (@(posedge clock) disable iff (!rst_n_r)
    |no_hit |=> ext_trip_a_r ##1 output_block_r)
    else $error("n.o. short did not block output");
  AST_NC_TRIP: assert property (@(posedge clock) disable iff (!rst_n_r)
    |nc_hit |=> ext_trip_b_r)
    else $error("n.c. open did not trip");
  AST_ADV_ONLY: assert property (@(posedge clock) disable iff (!rst_n_r)
    !advanced_io |-> (no_hit[4:3] == 2'h0 && nc_hit[4:3] == 2'h0))
    else $error("terminal four or five active on standard variant");
  AST_NC_HOLD: assert property (@(posedge clock) disable iff (!rst_n_r)
    (ext_trip_b_r && nc_mask_r != 5'h00 && !(|nc_hit)) |=> ext_trip_b_r)
    else $error("n.c. trip cleared while contact open");
  AST_OVL_RELAY: assert property (@(posedge clock) disable iff (!rst_n_r)
    (relay_function_select == pd_pkg::OUT_OVERLOAD && overload_latch_r) |=> fault_relay_contact_r)
    else $error("relay missed overload trip");
  AST_MODE_OFF: assert property (@(posedge clock) disable iff (!rst_n_r)
    (loss_detect_mode == pd_pkg::MODE_OFF) |=> !speed_loss_r)
    else $error("loss flagged with detection off");
  AST_CONFIRM: assert property (@(posedge clock) disable iff (!rst_n_r)
    $rose(speed_loss_r) |-> $past(loss_cond) && $past(confirm_r) >= $past(confirm_lim))
    else $error("loss declared before confirm time");
  AST_LOSS_OUT2: assert property (@(posedge clock) disable iff (!rst_n_r)
    (output_two_function_select == pd_pkg::OUT_SPEED_LOSS && speed_loss_r) |=> output_two_r)
    else $error("output two missed loss status");
  AST_FREE_STOP: assert property (@(posedge clock) disable iff (!rst_n_r)
    (speed_loss_r && loss_reaction_select == pd_pkg::REACT_FREE) |=> ##1 output_block_r)
    else $error("free run reaction did not block");
  AST_BRAKE_CUT: assert property (@(posedge clock) disable iff (!rst_n_r)
    (brake_st_r == pd_pkg::PD_BR_HOLD) |=> !brake_drive_r)
    else $error("brake driven past continuous limit");
  AST_DUTY: assert property (@(posedge clock) disable iff (!rst_n_r)
    (brake_limit_enable && on_r >= {2'h0, duty_lim}) |=> !brake_drive_r)
    else $error("brake driven beyond enable duty");
endmodule // pd_trip

// ### rtl/pd_pkg.sv
package pd_pkg;
  // clock and time base
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // terminal functions
  localparam logic [4:0] FN_MAX = 5'h1b;
  localparam logic [4:0] FN_EXT_TRIP_NO = 5'h12;
  localparam logic [4:0] FN_EXT_TRIP_NC = 5'h13;
  localparam int TERMS = 5;
  localparam int STD_TERMS = 3;
  localparam logic [4:0] FSEL_RST = 5'h00;
  // output selectors
  localparam logic [4:0] OUT_OVERLOAD = 5'h06;
  localparam logic [4:0] OUT_SPEED_LOSS = 5'h0b;
  // loss detection modes and reactions
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_HALF = 2'h1;
  localparam logic [1:0] MODE_FULL = 2'h2;
  localparam logic [1:0] REACT_RUN = 2'h0;
  localparam logic [1:0] REACT_FREE = 2'h1;
  localparam logic [1:0] REACT_DECEL = 2'h2;
  // confirm time in tenths of a second
  localparam logic [10:0] CONFIRM_MIN = 11'h001;
  localparam logic [10:0] CONFIRM_MAX = 11'h4b0;
  localparam logic [10:0] CONFIRM_RST = 11'h00a;
  // braking resistor
  localparam logic BRAKE_LIMIT_RST = 1'b1;
  localparam logic [4:0] DUTY_MAX = 5'h1e;
  localparam logic [4:0] DUTY_RST = 5'h0a;
  localparam int PERCENT = 100;
  localparam int BRAKE_CONT_S = 15;
  localparam logic [7:0] BRAKE_CONT_TICKS = 8'(BRAKE_CONT_S * 1000 / TICK_MS);
  localparam logic [6:0] DUTY_WINDOW_TICKS = 7'(PERCENT);
  // brake state machine
  typedef enum logic [2:0] {
    PD_BR_IDLE = 3'b001,
    PD_BR_ON = 3'b010,
    PD_BR_HOLD = 3'b100
  } pd_brake_t;
endpackage

// ### rtl/pd_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for contact pins
module pd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // pd_sync

// ### rtl/pd_tick.sv
`timescale 1ns/1ps
// divider giving a one-cycle enable every period
module pd_tick #(
  parameter int PERIOD = 2000000
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] count_r;

  // count up, pulse on wrap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 32'h0;
      tick <= 1'b0;
    end else if (count_r == 32'(PERIOD - 1)) begin
      count_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      count_r <= count_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // pd_tick

// ### test/pd_far_model.sv
`timescale 1ns/1ps
// contacts and analog source facing the trip block
module pd_far_model (
  input wire logic [4:0] contact_cmd,
  input wire logic [11:0] volt_cmd,
  input wire logic [11:0] curr_cmd,
  output logic [4:0] term_closed,
  output logic [11:0] voltage_level,
  output logic [11:0] current_level
);
  // bit high means contact shorted to common
  assign term_closed = contact_cmd;
  // both channels always present, only combined mode reads current
  assign voltage_level = volt_cmd;
  assign current_level = curr_cmd;
endmodule // pd_far_model

// ### test/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the trip block
module tb_top;
  localparam int TC = 10;
  localparam logic [11:0] AMIN = 12'h400;
  localparam logic [11:0] VMIN = 12'h300;
  localparam logic [11:0] CMIN = 12'h300;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic adv = 1'b0, clr = 1'b0, ovl = 1'b0, ana = 1'b1, comm = 1'b0, comb = 1'b0, lost = 1'b0;
  logic brk_en = 1'b0, brk_req = 1'b0;
  logic [4:0] fsel [0:4] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
  logic [4:0] contact = 5'h00, rsel = 5'h00, osel = 5'h00, duty = 5'h00;
  logic [1:0] mode = 2'h0, react = 2'h0;
  logic [10:0] conf = 11'h002;
  logic [11:0] vcmd = 12'hfff, ccmd = 12'hfff;
  wire [4:0] tclosed;
  wire [11:0] vlev, clev;
  wire [8:0] outs;
  int miscompares = 0, n_checks = 0, seed;

  // 20 mhz clock
  always #25 clock = ~clock;

  pd_far_model far (.contact_cmd(contact), .volt_cmd(vcmd), .curr_cmd(ccmd), .term_closed(tclosed),
    .voltage_level(vlev), .current_level(clev));

  // short tick keeps confirm and brake counts in reach
  pd_trip #(.TICK_CYCLES(TC)) dut (.clock(clock), .rstn(rstn), .advanced_io(adv), .term_closed(tclosed),
    .input_one_function_select(fsel[0]), .input_two_function_select(fsel[1]),
    .input_three_function_select(fsel[2]), .input_four_function_select(fsel[3]),
    .input_five_function_select(fsel[4]), .trip_clear(clr), .overload_trip(ovl),
    .ref_is_analog(ana), .ref_is_comm(comm), .ref_combined(comb), .comm_lost(lost),
    .voltage_level(vlev), .current_level(clev), .analog_input_min_level(AMIN),
    .voltage_input_min_level(VMIN), .current_input_min_level(CMIN), .loss_detect_mode(mode),
    .loss_reaction_select(react), .loss_confirm_time(conf), .relay_function_select(rsel),
    .output_two_function_select(osel), .brake_limit_enable(brk_en), .brake_enable_duty(duty),
    .brake_request(brk_req), .output_block_r(outs[0]), .decel_stop_r(outs[1]), .ext_trip_a_r(outs[2]),
    .ext_trip_b_r(outs[3]), .overload_latch_r(outs[4]), .speed_loss_r(outs[5]),
    .fault_relay_contact_r(outs[6]), .output_two_r(outs[7]), .brake_drive_r(outs[8]));

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic check_num(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // inputs only move at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wait_for(input int idx, input logic val, input int bound);
    for (int k = 0; k < bound && outs[idx] !== val; k++) cyc(1);
    if (outs[idx] !== val) begin
      miscompares++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      test_done();
    end
  endtask

  task automatic pulse_clear();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(3);
  endtask

  function automatic logic exp_trip(input int t, input logic [4:0] s, input logic a);
    return (s == pd_pkg::FN_EXT_TRIP_NO || s == pd_pkg::FN_EXT_TRIP_NC) && (t < pd_pkg::STD_TERMS || a);
  endfunction

  function automatic logic exp_loss(input logic [1:0] m, input logic cb, input logic cm,
    input logic [11:0] v, input logic [11:0] c);
    logic [11:0] tv, tc;
    tv = cb ? VMIN : AMIN;
    tc = CMIN;
    // detection off gates the comm loss flag as well
    if (m == pd_pkg::MODE_OFF) return 1'b0;
    if (cm) return 1'b1;
    if (m == pd_pkg::MODE_HALF) begin
      tv = tv >> 1;
      tc = tc >> 1;
    end
    return v < tv || (cb && c < tc);
  endfunction

  // normal contact state first, then trip it, clear with and without cause
  task automatic trip_case(input int t, input logic [4:0] s, input logic a);
    logic nc, e;
    nc = s == pd_pkg::FN_EXT_TRIP_NC;
    e = exp_trip(t, s, a);
    contact[t] = nc;
    cyc(4);
    fsel[t] = s;
    adv = a;
    cyc(4);
    check_bit(outs[0], 1'b0);
    contact[t] = !nc;
    if (e) begin
      wait_for(nc ? 3 : 2, 1'b1, 8);
      wait_for(0, 1'b1, 3);
      check_bit(outs[0], 1'b1);
      pulse_clear();
      check_bit(outs[nc ? 3 : 2], 1'b1);
    end else begin
      cyc(8);
      check_bit(outs[0], 1'b0);
    end
    if (e && nc) begin
      fsel[t] = 5'h00;
      pulse_clear();
      check_bit(outs[3], 1'b1);
    end
    contact[t] = nc;
    cyc(4);
    pulse_clear();
    check_bit(outs[nc ? 3 : 2] | outs[0], 1'b0);
    fsel[t] = pd_pkg::FSEL_RST;
  endtask

  task automatic loss_case(input logic [1:0] m, input logic [1:0] r, input logic cb, input logic cm,
    input logic [11:0] v, input logic [11:0] c);
    logic e;
    e = exp_loss(m, cb, cm, v, c);
    mode = m;
    react = r;
    comb = cb;
    comm = cm;
    ana = !cm;
    lost = cm;
    vcmd = v;
    ccmd = c;
    cyc(TC - 2);
    check_bit(outs[5], 1'b0);
    if (e) wait_for(5, 1'b1, 8 * TC);
    else cyc(8 * TC);
    check_bit(outs[5], e);
    cyc(2);
    check_bit(outs[6] & outs[7], e);
    check_bit(outs[0], e && r == pd_pkg::REACT_FREE);
    check_bit(outs[1], e && r == pd_pkg::REACT_DECEL);
    vcmd = 12'hfff;
    ccmd = 12'hfff;
    lost = 1'b0;
    cyc(4);
    check_bit(outs[5], 1'b0);
    check_bit(outs[0], e && r == pd_pkg::REACT_FREE);
    pulse_clear();
    check_bit(outs[0] | outs[1], 1'b0);
  endtask

  // idle first so the duty window holds no earlier on-time
  task automatic brake_case(input logic en, input logic [4:0] d);
    int hi, dd;
    dd = d > pd_pkg::DUTY_MAX ? 30 : d;
    brk_en = en;
    duty = d;
    cyc(1100);
    brk_req = 1'b1;
    hi = 0;
    for (int k = 0; k < (en ? 900 : 1800); k++) begin
      cyc(1);
      hi += (outs[8] === 1'b1);
    end
    brk_req = 1'b0;
    if (en) check_num(hi, (dd > 0 ? dd - 1 : 0) * TC, (2 * dd + 1) * TC + 5);
    else check_num(hi, 149 * TC, 151 * TC + 5);
    cyc(4);
    check_bit(outs[8], 1'b0);
  endtask

  initial begin
    seed = $urandom(16681);
    repeat (3) @(posedge clock);
    cyc(1);
    rstn = 1'b1;
    cyc(4);
    for (int i = 0; i < 9; i++) check_bit(outs[i], 1'b0);
    trip_case(0, pd_pkg::FN_EXT_TRIP_NO, 1'b1);
    trip_case(4, pd_pkg::FN_EXT_TRIP_NC, 1'b1);
    trip_case(3, pd_pkg::FN_EXT_TRIP_NO, 1'b0);
    trip_case(int'($urandom % 5), pd_pkg::FN_EXT_TRIP_NC, 1'($urandom));
    trip_case(1, 5'h1c, 1'b1);
    trip_case(int'($urandom % 3), pd_pkg::FN_EXT_TRIP_NO, 1'b0);
    rsel = pd_pkg::OUT_SPEED_LOSS;
    osel = pd_pkg::OUT_SPEED_LOSS;
    loss_case(pd_pkg::MODE_OFF, pd_pkg::REACT_RUN, 1'b0, 1'b0, 12'h000, 12'hfff);
    loss_case(pd_pkg::MODE_HALF, pd_pkg::REACT_FREE, 1'b0, 1'b0, 12'h300, 12'hfff);
    loss_case(pd_pkg::MODE_HALF, pd_pkg::REACT_FREE, 1'b0, 1'b0, 12'($urandom % 512), 12'hfff);
    loss_case(pd_pkg::MODE_FULL, pd_pkg::REACT_DECEL, 1'b0, 1'b0, 12'h3ff, 12'hfff);
    loss_case(pd_pkg::MODE_FULL, pd_pkg::REACT_RUN, 1'b1, 1'b0, 12'hfff, 12'($urandom % 768));
    loss_case(pd_pkg::MODE_HALF, pd_pkg::REACT_DECEL, 1'b1, 1'b0, 12'hfff, 12'h200);
    loss_case(pd_pkg::MODE_FULL, pd_pkg::REACT_FREE, 1'b0, 1'b1, 12'hfff, 12'hfff);
    loss_case(pd_pkg::MODE_OFF, pd_pkg::REACT_FREE, 1'b0, 1'b1, 12'hfff, 12'hfff);
    // overload trip on relay, then on output two
    for (int w = 0; w < 2; w++) begin
      rsel = w ? pd_pkg::OUT_SPEED_LOSS : pd_pkg::OUT_OVERLOAD;
      osel = w ? pd_pkg::OUT_OVERLOAD : pd_pkg::OUT_SPEED_LOSS;
      cyc(2);
      ovl = 1'b1;
      cyc(1);
      ovl = 1'b0;
      wait_for(4, 1'b1, 4);
      wait_for(w ? 7 : 6, 1'b1, 3);
      check_bit(outs[w ? 7 : 6], 1'b1);
      check_bit(outs[w ? 6 : 7], 1'b0);
      pulse_clear();
      check_bit(outs[4], 1'b0);
    end
    brake_case(1'b0, 5'h0a);
    brake_case(1'b1, 5'h00);
    brake_case(1'b1, 5'h1f);
    brake_case(1'b1, 5'(1 + $urandom % 29));
    test_done();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    $display("CHECK FAILED t=%0t run too long", $time);
    test_done();
  end
endmodule // tb_top
